//--- solcfg_checker.sv
/* Port checker for solcfg_regs.
   Assumes one clock and binding to every solcfg_regs instance. */
`timescale 1ns/1ps
module solcfg_checker (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic spi_select_n_in,
	input wire logic spi_sclk_in,
	input wire logic spi_sdio_in,
	input wire logic spi_sdio_out,
	input wire logic spi_sdio_oe_out,
	input solcfg_pkg::solcfg_status_t status_in,
	input solcfg_pkg::solcfg_ctrl_t ctrl_out
);
	import solcfg_pkg::*;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	a_ctrl_reset: assert property ($rose(arst_n_in) |-> ctrl_out == 24'h068800)
		else $error("ctrl reset");
	a_idle_no_drive: assert property (spi_select_n_in [*8] |-> !spi_sdio_oe_out)
		else $error("idle drive");
	a_drive_release: assert property ($rose(spi_select_n_in) |-> ##[1:8] !spi_sdio_oe_out)
		else $error("no release");
	a_idle_hold: assert property (spi_select_n_in [*8] |=> $stable(ctrl_out))
		else $error("idle write");
	a_sdo_steady: assert property ((spi_sclk_in && !spi_select_n_in) [*6] |=> $stable(spi_sdio_out))
		else $error("sdo moved");
	a_drive_selected: assert property ($rose(spi_sdio_oe_out) |-> !$past(spi_select_n_in, 8))
		else $error("drive unselected");
	a_drive_on_fall: assert property ($rose(spi_sdio_oe_out) |-> !$past(spi_sclk_in, 2))
		else $error("drive off fall");
	a_write_on_rise: assert property ($changed(ctrl_out) |-> $past(spi_sclk_in))
		else $error("write off rise");
	cover property ($rose(spi_sdio_oe_out));
	cover property ($changed(ctrl_out.lane_select));
	cover property ($changed(ctrl_out.swing));
endmodule : solcfg_checker

bind solcfg_regs solcfg_checker u_chk (.mclk_in, .arst_n_in, .spi_select_n_in, .spi_sclk_in, .spi_sdio_in,
	.spi_sdio_out, .spi_sdio_oe_out, .status_in, .ctrl_out);

//--- solcfg_link_model.sv
/* Link layer stand-in giving steady status.
   Assumes the bank samples it on its own clock. */
`timescale 1ns/1ps
module solcfg_link_model (
	input wire logic alt_image_in,
	output solcfg_pkg::solcfg_status_t status_out
);
	import solcfg_pkg::*;
	// first image equals the reset image, so reads do not jump after reset;
	// the second differs in every field, so a stuck mirror shows up
	assign status_out = alt_image_in ? {1'b0, 5'h15, 32'h5A4B3C2D} : {1'b1, 5'h00, 32'hC9C7C5C3};
endmodule : solcfg_link_model

//--- solcfg_pkg.sv
/*
 * Constants, types and register map for the serial lane output
 * configuration bank. Assumes one clock domain and a 3-wire serial
 * control port driven by the host.
 */
package solcfg_pkg;

	localparam int SOLCFG_ADDR_W = 15;
	localparam int SOLCFG_INSTR_BITS = 16;
	localparam logic [3:0] SOLCFG_INSTR_LAST = 4'hF;
	localparam logic [3:0] SOLCFG_DATA_LAST = 4'h7;

	// register offsets
	localparam logic [14:0] OFS_DENSITY = 15'h0592;
	localparam logic [14:0] OFS_CHECKSUM [4] = '{15'h05A0, 15'h05A2, 15'h05A4, 15'h05A6};
	localparam logic [14:0] OFS_POWER_DOWN = 15'h05B0;
	localparam logic [14:0] OFS_ASSIGN [4] = '{15'h05B2, 15'h05B3, 15'h05B5, 15'h05B6};
	localparam logic [14:0] OFS_SWING = 15'h05BF;
	localparam logic [14:0] OFS_DEEMPH = 15'h05C1;

	// values after reset
	localparam logic [7:0] RST_DENSITY = 8'h80;
	localparam logic [7:0] RST_CHECKSUM [4] = '{8'hC3, 8'hC5, 8'hC7, 8'hC9};
	localparam logic [7:0] RST_POWER_DOWN = 8'hAA;
	localparam logic [7:0] RST_ASSIGN [4] = '{8'h00, 8'h11, 8'h22, 8'h33};
	localparam logic [3:0] RST_SWING = 4'h0;
	localparam logic [7:0] RST_DEEMPH = 8'h00;
	// pin order {select_n, sclk, sdio}; select idles high
	localparam logic [2:0] RST_PINS = 3'h4;

	// field positions
	localparam int POS_DENSITY_FLAG = 7;
	localparam int POS_LANE_STRIDE = 2;
	localparam int POS_ASSIGN_HI = 4;

	typedef enum logic [1:0] {
		SOLCFG_ST_INSTR = 2'b00,
		SOLCFG_ST_WRITE = 2'b01,
		SOLCFG_ST_READ = 2'b10
	} solcfg_state_t;

	typedef struct packed {
		logic [3:0] power_down;
		logic [3:0][2:0] lane_select;
		logic [3:0] swing;
		logic [3:0] deemph_enable;
	} solcfg_ctrl_t;

	typedef struct packed {
		logic high_density_flag;
		logic [4:0] control_words_per_frame;
		logic [3:0][7:0] lane_config_checksum;
	} solcfg_status_t;

endpackage : solcfg_pkg

//--- solcfg_regs.sv
/*
 * Serial lane output configuration register bank with its 3-wire
 * serial control port slave (select, clock, bidirectional data).
 * Assumes the host's port pins are asynchronous to mclk_in and slow
 * enough to be oversampled, and that link status arrives on mclk_in.
 */
`timescale 1ns/1ps
module solcfg_regs (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic spi_select_n_in,
	input wire logic spi_sclk_in,
	input wire logic spi_sdio_in,
	output logic spi_sdio_out,
	output logic spi_sdio_oe_out,
	input solcfg_pkg::solcfg_status_t status_in,
	output solcfg_pkg::solcfg_ctrl_t ctrl_out
);
	import solcfg_pkg::*;

	// pin synchronisers: stage one feeds only stage two
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] pin_filt;
	wire [2:0] pin_agree = ~(sync2 ^ sync3);
	wire [2:0] next_pin_filt = (sync3 & pin_agree) | (pin_filt & ~pin_agree);

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1 <= RST_PINS;
			sync2 <= RST_PINS;
			sync3 <= RST_PINS;
			pin_filt <= RST_PINS;
		end else begin
			sync1 <= {spi_select_n_in, spi_sclk_in, spi_sdio_in};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_filt <= next_pin_filt;
		end
	end

	// edges come from the filtered level, so a one-sample spike never clocks the port
	wire port_idle = pin_filt[2];
	wire sclk_rise = ~port_idle & next_pin_filt[1] & ~pin_filt[1];
	wire sclk_fall = ~port_idle & ~next_pin_filt[1] & pin_filt[1];
	wire sdio_bit = pin_filt[0];

	// serial port state
	solcfg_state_t state;
	logic [3:0] bit_cnt;
	logic [14:0] shift_in;
	logic [14:0] addr;
	logic [7:0] rd_shift;

	wire [15:0] instr_word = {shift_in, sdio_bit};
	wire [7:0] wr_byte = {shift_in[6:0], sdio_bit};
	wire instr_done = sclk_rise && state == SOLCFG_ST_INSTR && bit_cnt == SOLCFG_INSTR_LAST;
	wire byte_done = sclk_rise && state != SOLCFG_ST_INSTR && bit_cnt == SOLCFG_DATA_LAST;
	wire wr_en = byte_done && state == SOLCFG_ST_WRITE;
	wire [14:0] next_addr = addr + 15'h0001;
	// one counter serves both fields: 16 instruction bits, then 8 per data byte
	wire [3:0] next_bit_cnt = (instr_done || byte_done) ? 4'h0 : bit_cnt + 4'h1;

	// registers software owns, then the read-only link mirrors density and checksum
	solcfg_ctrl_t ctrl;
	// upper nibble of each assign register is kept for read-back only
	logic [3:0][3:0] assign_hi;
	logic [7:0] density;
	logic [3:0][7:0] checksum;

	// read path, unmapped addresses read zero
	wire hit_density = addr == OFS_DENSITY;
	wire hit_power = addr == OFS_POWER_DOWN;
	wire hit_swing = addr == OFS_SWING;
	wire hit_deemph = addr == OFS_DEEMPH;
	logic [3:0] hit_assign;
	logic [3:0] hit_checksum;
	logic [3:0][7:0] rd_lane;
	logic [7:0] rd_power;
	logic [7:0] rd_deemph;
	// swing codes pass to the serializer unchanged: all sixteen are legal
	wire [7:0] rd_swing = {4'h0, ctrl.swing};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign hit_assign[gi] = addr == OFS_ASSIGN[gi];
			assign hit_checksum[gi] = addr == OFS_CHECKSUM[gi];
			assign rd_lane[gi] = (hit_assign[gi] ? {assign_hi[gi], 1'b0, ctrl.lane_select[gi]} : 8'h00) |
				(hit_checksum[gi] ? checksum[gi] : 8'h00);
			assign rd_power[POS_LANE_STRIDE*gi +: 2] = {1'b1, ctrl.power_down[gi]};
			assign rd_deemph[POS_LANE_STRIDE*gi +: 2] = {1'b0, ctrl.deemph_enable[gi]};
		end
	endgenerate

	wire [7:0] rd_fixed = (hit_density ? density : 8'h00) |
		(hit_power ? rd_power : 8'h00) |
		(hit_swing ? rd_swing : 8'h00) |
		(hit_deemph ? rd_deemph : 8'h00);
	wire [7:0] read_data = rd_fixed | rd_lane[0] | rd_lane[1] | rd_lane[2] | rd_lane[3];

	// write strobes, one per writable register; read-only offsets get none
	wire wr_power = wr_en && hit_power;
	wire wr_deemph = wr_en && hit_deemph;
	wire wr_swing = wr_en && hit_swing;
	wire [3:0] wr_assign = {4{wr_en}} & hit_assign;

	// instruction: read flag then 15-bit address; streams step upward
	// select high aborts at any bit, so a partial byte never reaches a register
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= SOLCFG_ST_INSTR;
			bit_cnt <= 4'h0;
			shift_in <= 15'h0000;
			addr <= 15'h0000;
		end else if (port_idle) begin
			state <= SOLCFG_ST_INSTR;
			bit_cnt <= 4'h0;
		end else if (sclk_rise) begin
			shift_in <= instr_word[14:0];
			bit_cnt <= next_bit_cnt;
			case (state)
				SOLCFG_ST_INSTR: begin
					if (instr_done) begin
						addr <= instr_word[14:0];
						state <= instr_word[15] ? SOLCFG_ST_READ : SOLCFG_ST_WRITE;
					end
				end
				SOLCFG_ST_WRITE, SOLCFG_ST_READ: begin
					if (byte_done) begin
						addr <= next_addr;
					end
				end
				default: begin
					state <= SOLCFG_ST_INSTR;
				end
			endcase
		end
	end

	wire rd_active = !port_idle && state == SOLCFG_ST_READ;
	// first fall of each byte reloads from the map, so streams see the new address
	wire rd_first = bit_cnt == 4'h0;

	// read data leaves on falling clock so the host samples on rising
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_shift <= 8'h00;
			spi_sdio_out <= 1'b0;
			spi_sdio_oe_out <= 1'b0;
		end else if (!rd_active) begin
			spi_sdio_oe_out <= 1'b0;
		end else if (sclk_fall) begin
			spi_sdio_oe_out <= 1'b1;
			if (rd_first) begin
				spi_sdio_out <= read_data[7];
				rd_shift <= {read_data[6:0], 1'b0};
			end else begin
				spi_sdio_out <= rd_shift[7];
				rd_shift <= {rd_shift[6:0], 1'b0};
			end
		end
	end

	// software-written control, driven straight to the serializer
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < 4; i++) begin
				ctrl.power_down[i] <= RST_POWER_DOWN[POS_LANE_STRIDE*i];
				ctrl.lane_select[i] <= RST_ASSIGN[i][2:0];
				assign_hi[i] <= RST_ASSIGN[i][POS_ASSIGN_HI +: 4];
				ctrl.deemph_enable[i] <= RST_DEEMPH[POS_LANE_STRIDE*i];
			end
			ctrl.swing <= RST_SWING;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_power) begin
					ctrl.power_down[i] <= wr_byte[POS_LANE_STRIDE*i];
				end
				if (wr_deemph) begin
					ctrl.deemph_enable[i] <= wr_byte[POS_LANE_STRIDE*i];
				end
				if (wr_assign[i]) begin
					ctrl.lane_select[i] <= wr_byte[2:0];
					assign_hi[i] <= wr_byte[POS_ASSIGN_HI +: 4];
				end
			end
			if (wr_swing) begin
				ctrl.swing <= wr_byte[3:0];
			end
		end
	end

	// reserved bits 6:5 are forced low so nothing else can leak into them
	wire [7:0] next_density = {status_in.high_density_flag, 2'b00, status_in.control_words_per_frame};
	wire [3:0][7:0] next_checksum = status_in.lane_config_checksum;

	// read-only link parameters, refreshed every cycle from the link layer
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			density <= RST_DENSITY;
			for (int i = 0; i < 4; i++) begin
				checksum[i] <= RST_CHECKSUM[i];
			end
		end else begin
			density <= next_density;
			checksum <= next_checksum;
		end
	end

	assign ctrl_out = ctrl;

endmodule : solcfg_regs

//--- solcfg_regs_tb_top.sv
/* Scenario testbench for solcfg_regs over its serial port.
   Assumes the link model drives status. */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("mismatch %0t %h", $time, a); end end
module solcfg_regs_tb_top;
	import solcfg_pkg::*;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic sel_n = 1'b1;
	logic sclk = 1'b0;
	logic h_oe = 1'b1;
	logic h_d = 1'b0;
	logic alt_img = 1'b0;
	logic dout;
	logic oe;
	// undriven line shows the inverse so stale data never reads back
	wire sio = oe ? dout : (h_oe ? h_d : ~h_d);
	solcfg_status_t st;
	solcfg_ctrl_t ctrl;
	int error_cnt = 0;
	int cmp_count = 0;
	always #2 mclk_in = ~mclk_in;
	solcfg_link_model link (.alt_image_in(alt_img), .status_out(st));
	solcfg_regs dut (.mclk_in, .arst_n_in, .spi_select_n_in(sel_n), .spi_sclk_in(sclk), .spi_sdio_in(sio),
		.spi_sdio_out(dout), .spi_sdio_oe_out(oe), .status_in(st), .ctrl_out(ctrl));
	// phases of 7 cycles cover the 4 cycle filter margin
	task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] rd);
		sel_n = 1'b0;
		for (int i = 31; i > 31 - n; i--) begin
			h_oe = (i > 15) || !w[31];
			h_d = w[i];
			repeat (7) @(negedge mclk_in);
			rd = {rd[6:0], sio};
			sclk = 1'b1;
			repeat (7) @(negedge mclk_in);
			sclk = 1'b0;
		end
		repeat (7) @(negedge mclk_in);
		sel_n = 1'b1;
		h_oe = 1'b1;
		repeat (8) @(negedge mclk_in);
	endtask : xfer
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] x;
		xfer({1'b0, a, d, 8'h00}, 24, x);
	endtask : wr
	task automatic rdc(input logic [14:0] a, input logic [7:0] e);
		logic [7:0] x;
		xfer({1'b1, a, 16'h0000}, 24, x);
		`CHK(x, e)
	endtask : rdc
	task automatic t_reset_image;
		rdc(OFS_DENSITY, 8'h80);
		for (int i = 0; i < 4; i++) begin
			rdc(OFS_CHECKSUM[i], 8'(8'hC3 + 2 * i));
			rdc(OFS_ASSIGN[i], 8'(8'h11 * i));
		end
		rdc(OFS_POWER_DOWN, 8'hAA);
		rdc(OFS_SWING, 8'h00);
		rdc(OFS_DEEMPH, 8'h00);
		`CHK(ctrl, 24'h068800)
	endtask : t_reset_image
	task automatic t_write_fields;
		wr(OFS_POWER_DOWN, 8'h41);
		rdc(OFS_POWER_DOWN, 8'hEB);
		`CHK(ctrl.power_down, 4'h9)
		wr(OFS_DEEMPH, 8'hFF);
		rdc(OFS_DEEMPH, 8'h55);
		`CHK(ctrl.deemph_enable, 4'hF)
		wr(OFS_SWING, 8'hAF);
		rdc(OFS_SWING, 8'h0F);
		`CHK(ctrl.swing, 4'hF)
		for (int i = 0; i < 4; i++) begin
			wr(OFS_ASSIGN[i], 8'(11 - i));
		end
		rdc(OFS_ASSIGN[0], 8'h03);
		`CHK(ctrl.lane_select, 12'h053)
	endtask : t_write_fields
	task automatic t_refused;
		logic [7:0] x;
		wr(OFS_DENSITY, 8'h00);
		rdc(OFS_DENSITY, 8'h80);
		wr(OFS_CHECKSUM[3], 8'h00);
		rdc(OFS_CHECKSUM[3], 8'hC9);
		rdc(15'h05B1, 8'h00);
		xfer({1'b0, OFS_SWING, 8'h05, 8'h00}, 20, x);
		`CHK(ctrl.swing, 4'hF)
	endtask : t_refused
	task automatic t_status_follow;
		alt_img = 1'b1;
		rdc(OFS_DENSITY, 8'h15);
		rdc(OFS_CHECKSUM[0], 8'h2D);
		rdc(OFS_CHECKSUM[3], 8'h5A);
		alt_img = 1'b0;
	endtask : t_status_follow
	task automatic t_stream;
		logic [7:0] x;
		xfer({1'b0, OFS_ASSIGN[0], 8'h02, 8'h71}, 32, x);
		`CHK(ctrl.lane_select, 12'h04A)
		xfer({1'b1, OFS_ASSIGN[0], 16'h0000}, 32, x);
		`CHK(x, 8'h71)
	endtask : t_stream
	task automatic t_mid_reset;
		arst_n_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		arst_n_in = 1'b1;
		repeat (8) @(negedge mclk_in);
		`CHK(ctrl, 24'h068800)
		rdc(OFS_ASSIGN[3], 8'h33);
		rdc(OFS_POWER_DOWN, 8'hAA);
	endtask : t_mid_reset
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (12) @(negedge mclk_in);
		arst_n_in = 1'b1;
		repeat (8) @(negedge mclk_in);
		t_reset_image();
		t_status_follow();
		t_write_fields();
		t_stream();
		t_refused();
		t_mid_reset();
		stop_test();
	end
	initial begin
		repeat (60000) @(negedge mclk_in);
		error_cnt++;
		stop_test();
	end
endmodule : solcfg_regs_tb_top
